// ===== rtc_timer_regs.svh
// register offsets, field positions, reset values and timing of the rtc timer
`ifndef RTC_TIMER_REGS_SVH
`define RTC_TIMER_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_IRQ_MASK 8'h1C
`define OFS_RAW_STATUS 8'h20
`define OFS_MASKED_STATUS 8'h24
`define OFS_IRQ_CLEAR 8'h28
`define OFS_DOWN_COUNT 8'h2C
`define OFS_TIMER_CONTROL 8'h30
`define OFS_FIRST_RELOAD 8'h34
`define OFS_SECOND_RELOAD 8'h38
`define OFS_PATTERN_BASE 8'h3C
`define OFS_PATTERN_LAST 8'h48

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TCR_RUN_BIT 0
`define TCR_ONESHOT_BIT 1
`define TCR_SELFSTART_BIT 2
`define TCR_LEN_LSB 4
`define TCR_LEN_MSB 10
`define TCR_USED_MASK 32'h000007F7
`define TIMER_IRQ_BIT 1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TCR_RESET 32'h00000000
`define DOWN_COUNT_RESET 32'h0FFFFFFF
`define RELOAD_RESET 32'h00000000
`define IRQ_MASK_RESET 1'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SYS_PERIOD_NS 50
`define LS_PERIOD_NS 31250
`define TCR_WRITE_GAP_NS (3 * `LS_PERIOD_NS + 2 * `SYS_PERIOD_NS)
`define TCR_WRITE_GAP_CYC ((`TCR_WRITE_GAP_NS + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)

`endif

// ===== rtc_timer_pkg.sv
// types shared by the rtc down timer files
package rtc_timer_pkg;

   // bus data word
   typedef logic [31:0] word_t;

   // counter sequencer states, one-hot
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_COUNT = 2'b10
   } timer_state_e;

endpackage

// ===== lsclk_edge_sync.sv
// three-stage synchroniser and rising-edge pulse for the low-speed clock pin
`timescale 1ns/10ps
module lsclk_edge_sync (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic pin_i,
   output logic rise_o
);

   logic s1; // first stage, read only by s2
   logic s2; // second stage
   logic s3; // third stage
   logic level; // filtered level

   // ----------------------------------------------------------------
   // shift chain
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else begin
         s1 <= pin_i;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // ----------------------------------------------------------------
   // a change counts once stages two and three agree
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level <= 1'b0;
         rise_o <= 1'b0;
      end else begin
         rise_o <= (s2 == s3) && s3 && !level;
         if (s2 == s3) begin
            level <= s3;
         end
      end
   end

endmodule // lsclk_edge_sync

// ===== pattern_store.sv
// reload pattern memory: words written by software, registered read ports
`timescale 1ns/10ps
module pattern_store #(
   parameter int WORDS = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic we_i,
   input wire logic [$clog2(WORDS)-1:0] waddr_i,
   input wire rtc_timer_pkg::word_t wdata_i,
   input wire logic [3:0] be_i,
   input wire logic [$clog2(WORDS)-1:0] raddr_i,
   input wire logic [$clog2(WORDS*32)-1:0] bit_idx_i,
   output rtc_timer_pkg::word_t rdata_o,
   output logic bit_o
);
   import rtc_timer_pkg::*;

   word_t mem [WORDS]; // pattern words
   logic [WORDS*32-1:0] flat; // all pattern bits

   // ----------------------------------------------------------------
   // per-word write with byte enables
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < WORDS; g++) begin : g_word
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               mem[g] <= '0;
            end else if (we_i && waddr_i == g) begin
               for (int b = 0; b < 4; b++) begin
                  if (be_i[b]) begin
                     mem[g][b*8 +: 8] <= wdata_i[b*8 +: 8];
                  end
               end
            end
         end
         assign flat[g*32 +: 32] = mem[g];
      end
   endgenerate

   // ----------------------------------------------------------------
   // registered word read and pattern bit read
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_o <= '0;
         bit_o <= 1'b0;
      end else begin
         rdata_o <= mem[raddr_i];
         bit_o <= flat[bit_idx_i];
      end
   end

endmodule // pattern_store

// ===== rtc_dual_reload_down_timer.sv
// rtc down timer with dual reload values, reload pattern and wishbone slave
`timescale 1ns/10ps
`include "rtc_timer_regs.svh"
module rtc_dual_reload_down_timer #(
   parameter int PATTERN_BITS = 128
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic lsclk_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire rtc_timer_pkg::word_t wb_dat_i,
   output rtc_timer_pkg::word_t wb_dat_o,
   output logic wb_ack_o,
   output logic timer_zero_irq_o
);
   import rtc_timer_pkg::*;

   localparam int PW = $clog2(PATTERN_BITS / 32); // pattern word index width
   localparam int PB = $clog2(PATTERN_BITS); // pattern bit index width

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic tick; // one low-speed clock rising edge
   logic bus_req; // request present
   logic bus_wait; // first cycle of request seen
   logic wr_go; // write takes effect this edge
   word_t wmask; // byte enables as bit mask
   word_t wval; // merged write data helper
   word_t timer_control_reg; // applied control value
   word_t ctrl_pend; // staged control value
   logic ctrl_pend_v; // staged control waiting for tick
   word_t next_ctrl; // control value at next tick
   logic start_req; // reload write asks for restart
   word_t first_reload_value; // reload for pattern bit 0
   word_t second_reload_value; // reload for pattern bit 1
   word_t down_count_value; // counter
   logic [32:0] dec; // counter minus one with borrow
   logic borrow; // counter wraps past zero
   timer_state_e state; // sequencer state
   logic run_en; // applied run enable
   logic oneshot; // applied mode
   logic selfstart; // applied self-start
   logic [6:0] pat_len; // pattern bits in use
   logic [PB-1:0] pat_pos; // current pattern bit
   logic pat_bit; // pattern bit value
   word_t pat_rdata; // pattern word read
   logic wrap_evt; // counter passed zero while running
   logic load_evt; // periodic load that uses a pattern bit
   logic running; // counter busy, reloads locked
   logic raw_irq; // raw timer interrupt
   logic irq_mask; // 1 lets the interrupt out
   logic is_ctrl; // address hits control
   logic is_r1; // address hits first reload
   logic is_r2; // address hits second reload
   logic is_pat; // address hits pattern words
   logic reload_ok; // reload write accepted

   // ----------------------------------------------------------------
   // low-speed tick from pin
   // ----------------------------------------------------------------
   lsclk_edge_sync u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(lsclk_i),
      .rise_o(tick)
   );

   // ----------------------------------------------------------------
   // wishbone classic slave: ack two cycles after request
   // ----------------------------------------------------------------
   assign bus_req = wb_cyc_i && wb_stb_i;
   assign wr_go = bus_req && wb_ack_o && wb_we_i; // lands as ack is taken

   // byte lanes into a bit mask
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wmask[b*8 +: 8] = {8{wb_sel_i[b]}};
      end
   end

   // address decode
   assign is_ctrl = wb_adr_i == `OFS_TIMER_CONTROL;
   assign is_r1 = wb_adr_i == `OFS_FIRST_RELOAD;
   assign is_r2 = wb_adr_i == `OFS_SECOND_RELOAD;
   assign is_pat = wb_adr_i >= `OFS_PATTERN_BASE &&
                   wb_adr_i <= `OFS_PATTERN_LAST &&
                   wb_adr_i[1:0] == 2'h0;

   // handshake: wait one cycle for pattern read, then ack once
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_wait <= 1'b0;
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_req && bus_wait && !wb_ack_o;
         bus_wait <= bus_req && !bus_wait && !wb_ack_o;
      end
   end

   // read data registered with ack; unmapped reads zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= '0;
      end else if (bus_req && bus_wait && !wb_ack_o) begin
         case (wb_adr_i)
            `OFS_IRQ_MASK: wb_dat_o <= word_t'(irq_mask) << `TIMER_IRQ_BIT;
            `OFS_RAW_STATUS: begin
               wb_dat_o <= word_t'(raw_irq) << `TIMER_IRQ_BIT;
            end
            `OFS_MASKED_STATUS: begin
               wb_dat_o <= word_t'(raw_irq & irq_mask) << `TIMER_IRQ_BIT;
            end
            `OFS_DOWN_COUNT: wb_dat_o <= down_count_value;
            `OFS_TIMER_CONTROL: wb_dat_o <= timer_control_reg;
            `OFS_FIRST_RELOAD: wb_dat_o <= first_reload_value;
            `OFS_SECOND_RELOAD: wb_dat_o <= second_reload_value;
            default: wb_dat_o <= is_pat ? pat_rdata : '0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // control fields
   // ----------------------------------------------------------------
   assign run_en = timer_control_reg[`TCR_RUN_BIT];
   assign oneshot = timer_control_reg[`TCR_ONESHOT_BIT];
   assign selfstart = timer_control_reg[`TCR_SELFSTART_BIT];
   assign pat_len = timer_control_reg[`TCR_LEN_MSB:`TCR_LEN_LSB];
   assign running = run_en || (state == ST_COUNT);
   // base for a byte merge: a staged value not yet applied wins
   assign wval = ctrl_pend_v ? ctrl_pend : timer_control_reg;

   // ----------------------------------------------------------------
   // control staging: software value waits for a low-speed tick
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_pend <= `TCR_RESET;
         ctrl_pend_v <= 1'b0;
      end else if (wr_go && is_ctrl) begin
         ctrl_pend <= ((wval & ~wmask) | (wb_dat_i & wmask)) & `TCR_USED_MASK;
         ctrl_pend_v <= 1'b1;
      end else if (tick) begin
         ctrl_pend_v <= 1'b0;
      end
   end

   // control at next tick: staged write, then hardware stop and start
   always_comb begin
      next_ctrl = ctrl_pend_v ? ctrl_pend : timer_control_reg;
      if (wrap_evt && oneshot) begin
         next_ctrl[`TCR_RUN_BIT] = 1'b0;
      end
      if (start_req) begin
         next_ctrl[`TCR_RUN_BIT] = 1'b1;
      end
   end

   // applied control register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_control_reg <= `TCR_RESET;
      end else if (tick) begin
         timer_control_reg <= next_ctrl;
      end
   end

   // ----------------------------------------------------------------
   // reload registers: locked while running
   // ----------------------------------------------------------------
   assign reload_ok = wr_go && !running && (is_r1 || is_r2);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         first_reload_value <= `RELOAD_RESET;
         second_reload_value <= `RELOAD_RESET;
      end else if (reload_ok) begin
         if (is_r1) begin
            first_reload_value <= (first_reload_value & ~wmask) |
                                  (wb_dat_i & wmask);
         end else begin
            second_reload_value <= (second_reload_value & ~wmask) |
                                   (wb_dat_i & wmask);
         end
      end
   end

   // restart request after an accepted reload write with self-start, or a first reload write in one-shot, taken on tick
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         start_req <= 1'b0;
      end else if (reload_ok && (selfstart || (is_r1 && oneshot))) begin
         start_req <= 1'b1;
      end else if (tick) begin
         start_req <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // pattern memory
   // ----------------------------------------------------------------
   pattern_store #(
      .WORDS(PATTERN_BITS / 32)
   ) u_pat (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .we_i(wr_go && is_pat),
      .waddr_i(PW'((wb_adr_i - `OFS_PATTERN_BASE) >> 2)),
      .wdata_i(wb_dat_i),
      .be_i(wb_sel_i),
      .raddr_i(PW'((wb_adr_i - `OFS_PATTERN_BASE) >> 2)),
      .bit_idx_i(pat_pos),
      .rdata_o(pat_rdata),
      .bit_o(pat_bit)
   );

   // ----------------------------------------------------------------
   // down-counter
   // ----------------------------------------------------------------
   assign dec = {1'b0, down_count_value} - 33'h000000001;
   assign borrow = dec[32];
   assign wrap_evt = tick && state == ST_COUNT && run_en && borrow;
   // each periodic load, first or after a wrap, uses up one pattern bit
   assign load_evt = tick && run_en && !oneshot &&
                     (state == ST_IDLE || (state == ST_COUNT && borrow));

   // sequencer and count, advancing only on low-speed ticks
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
         down_count_value <= `DOWN_COUNT_RESET;
      end else if (tick) begin
         case (state)
            ST_IDLE: begin
               if (run_en) begin
                  down_count_value <= pat_bit ? second_reload_value
                                              : first_reload_value;
                  state <= ST_COUNT;
               end
            end
            ST_COUNT: begin
               if (!run_en) begin
                  state <= ST_IDLE;
               end else if (borrow) begin
                  if (oneshot) begin
                     state <= ST_IDLE;
                  end else begin
                     down_count_value <= pat_bit ? second_reload_value
                                                 : first_reload_value;
                  end
               end else begin
                  down_count_value <= dec[31:0];
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // pattern walk: a periodic load steps on to the next bit
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pat_pos <= '0;
      end else if (load_evt) begin
         if (7'(pat_pos) + 7'h01 >= pat_len || pat_len == 7'h00) begin
            pat_pos <= '0;
         end else begin
            pat_pos <= pat_pos + PB'(1);
         end
      end
   end

   // ----------------------------------------------------------------
   // interrupt status, mask and clear
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         raw_irq <= 1'b0;
      end else begin
         // a wrap in the clearing cycle keeps the flag set
         raw_irq <= (raw_irq && !(wr_go && wb_adr_i == `OFS_IRQ_CLEAR &&
                     wb_sel_i[0] && wb_dat_i[`TIMER_IRQ_BIT])) ||
                    wrap_evt;
      end
   end

   // mask register, 1 passes the interrupt
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask <= `IRQ_MASK_RESET;
      end else if (wr_go && wb_adr_i == `OFS_IRQ_MASK && wb_sel_i[0]) begin
         irq_mask <= wb_dat_i[`TIMER_IRQ_BIT];
      end
   end

   // interrupt output from flops
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_zero_irq_o <= 1'b0;
      end else begin
         timer_zero_irq_o <= raw_irq && irq_mask;
      end
   end

endmodule // rtc_dual_reload_down_timer

// ===== rtc_timer_sva.sv
// port checker for the rtc down timer bus and interrupt behaviour
`timescale 1ns/10ps
`include "rtc_timer_regs.svh"
module rtc_timer_sva #(
   parameter int PATTERN_BITS = 128
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic lsclk_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire rtc_timer_pkg::word_t wb_dat_i,
   input wire rtc_timer_pkg::word_t wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic timer_zero_irq_o
);
   import rtc_timer_pkg::*;
   // ----------------------------------------------------------------
   // helper logic
   // ----------------------------------------------------------------
   logic ls_q; // low-speed pin one clock ago
   logic [3:0] since_ls; // clocks since a low-speed rise, saturating
   logic [3:0] since_irqw; // clocks since a mask or clear write
   logic mask_seen; // mask bit as last written by software
   logic irq_wr; // mask or clear write completes now
   logic rd_ack; // read completes now
   logic mapped; // address falls on a register
   assign irq_wr = wb_ack_o && wb_we_i && wb_sel_i[0] &&
      (wb_adr_i == `OFS_IRQ_MASK || wb_adr_i == `OFS_IRQ_CLEAR);
   assign rd_ack = wb_ack_o && !wb_we_i;
   assign mapped = wb_adr_i >= `OFS_IRQ_MASK &&
      wb_adr_i <= `OFS_PATTERN_LAST && wb_adr_i[1:0] == 2'h0;
   // age of the last low-speed rising edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ls_q <= 1'b0;
         since_ls <= 4'hF;
      end else begin
         ls_q <= lsclk_i;
         if (lsclk_i && !ls_q) since_ls <= 4'h0;
         else if (since_ls != 4'hF) since_ls <= since_ls + 4'h1;
      end
   end
   // age of the last interrupt register write; reset excuses a drop
   always_ff @(posedge clk_i) begin
      if (rst_i) since_irqw <= 4'h0;
      else if (irq_wr) since_irqw <= 4'h0;
      else if (since_irqw != 4'hF) since_irqw <= since_irqw + 4'h1;
   end
   // shadow of the mask bit
   always_ff @(posedge clk_i) begin
      if (rst_i) mask_seen <= 1'b0;
      else if (irq_wr && wb_adr_i == `OFS_IRQ_MASK)
         mask_seen <= wb_dat_i[`TIMER_IRQ_BIT];
   end
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence req_taken;
      $rose(wb_cyc_i && wb_stb_i);
   endsequence
   sequence ack_in_time;
      !wb_ack_o ##1 !wb_ack_o ##[1:2] wb_ack_o;
   endsequence
   a_ack_latency: assert property (req_taken |-> ack_in_time)
      else $error("ack not given in time");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_needs_req: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
      else $error("ack without a request");
   a_unmapped_zero: assert property (rd_ack && !mapped |->
      wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   a_status_spare: assert property (rd_ack &&
      (wb_adr_i == `OFS_RAW_STATUS || wb_adr_i == `OFS_MASKED_STATUS) |->
      wb_dat_o[31:2] == 30'h0 && !wb_dat_o[0])
      else $error("status spare bits set");
   a_control_spare: assert property (rd_ack &&
      wb_adr_i == `OFS_TIMER_CONTROL |->
      (wb_dat_o & ~`TCR_USED_MASK) == 32'h0)
      else $error("control spare bits set");
   a_irq_holds: assert property (timer_zero_irq_o && !irq_wr &&
      since_irqw > 4'h2 |=> timer_zero_irq_o)
      else $error("interrupt dropped without clear");
   a_irq_fall_cause: assert property ($fell(timer_zero_irq_o) |->
      since_irqw < 4'h4)
      else $error("interrupt fell without a write");
   a_irq_rise_cause: assert property ($rose(timer_zero_irq_o) |->
      since_ls < 4'hC || since_irqw < 4'h4)
      else $error("interrupt rose without a tick");
   a_irq_mask_gate: assert property ($rose(timer_zero_irq_o) |->
      mask_seen)
      else $error("interrupt rose while masked");
   a_reset_quiet: assert property ($fell(rst_i) |->
      !timer_zero_irq_o [*8])
      else $error("interrupt after reset");
endmodule // rtc_timer_sva

bind rtc_dual_reload_down_timer rtc_timer_sva #(
   .PATTERN_BITS(PATTERN_BITS)
) chk (
   .clk_i(clk_i),
   .rst_i(rst_i),
   .lsclk_i(lsclk_i),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o),
   .timer_zero_irq_o(timer_zero_irq_o)
);

// ===== testbench.sv
// self-checking bench for the rtc down timer
`timescale 1ns/10ps
`include "rtc_timer_regs.svh"
module testbench;
   import rtc_timer_pkg::*;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic clk_i = 1'b0; // system clock
   logic rst_i = 1'b1; // synchronous reset
   logic lsclk_i = 1'b0; // low-speed clock
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hF;
   word_t wb_dat_i = 32'h0;
   word_t wb_dat_o;
   logic wb_ack_o;
   logic timer_zero_irq_o;
   int error_cnt = 0; // mismatches
   int compares = 0; // comparisons
   int ls_div = 0; // low-speed divider
   int tick_cnt = 0; // low-speed rising edges
   int t1, t2, t3; // tick stamps of interrupts
   word_t rd_val; // last read data
   typedef struct {logic we; logic [7:0] adr; word_t d;} row_s;
   // register table: reset-value reads first, then writes and reads with expected data
   row_s rows [20] = '{'{1'b0, 8'h1C, 32'h0}, '{1'b0, 8'h20, 32'h0},
      '{1'b0, 8'h24, 32'h0}, '{1'b0, 8'h2C, 32'h0FFFFFFF},
      '{1'b0, 8'h30, 32'h0}, '{1'b0, 8'h34, 32'h0}, '{1'b0, 8'h38, 32'h0},
      '{1'b0, 8'h3C, 32'h0}, '{1'b0, 8'h48, 32'h0}, '{1'b0, 8'h50, 32'h0},
      '{1'b1, 8'h50, 32'hFFFFFFFF}, '{1'b0, 8'h50, 32'h0},
      '{1'b1, 8'h34, 32'h3}, '{1'b1, 8'h38, 32'h5}, '{1'b1, 8'h3C, 32'h2},
      '{1'b1, 8'h2C, 32'h12345678}, '{1'b0, 8'h34, 32'h3},
      '{1'b0, 8'h38, 32'h5}, '{1'b0, 8'h3C, 32'h2},
      '{1'b0, 8'h2C, 32'h0FFFFFFF}};
   // ----------------------------------------------------------------
   // clocks and design
   // ----------------------------------------------------------------
   always #25 clk_i = ~clk_i;
   // low-speed clock: 625 system cycles per period
   always @(posedge clk_i) begin
      ls_div <= (ls_div == 624) ? 0 : ls_div + 1;
      lsclk_i <= (ls_div < 312);
      if (ls_div == 0) tick_cnt <= tick_cnt + 1;
   end
   rtc_dual_reload_down_timer #(.PATTERN_BITS(128)) dut (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .lsclk_i(lsclk_i),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .timer_zero_irq_o(timer_zero_irq_o)
   );
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task tally_and_finish;
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // a bound ran out
   task give_up;
      error_cnt++;
      $display("timeout at %0t", $time);
      tally_and_finish();
   endtask
   task automatic check(input word_t seen, input word_t exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one classic wishbone cycle, held until ack is sampled
   task automatic bus(input logic we, input logic [7:0] adr,
         input word_t wd, output word_t rd);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= wd;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 16);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      if (wb_ack_o !== 1'b1) give_up();
   endtask
   task automatic wr(input logic [7:0] adr, input word_t d);
      bus(1'b1, adr, d, rd_val);
   endtask
   task automatic rdchk(input logic [7:0] adr, input word_t exp);
      bus(1'b0, adr, 32'h0, rd_val);
      check(rd_val, exp);
   endtask
   // wait for the interrupt line within lim system cycles
   task automatic wait_irq(input int lim);
      int n;
      n = 0;
      // a line cleared by the last write only falls two edges after ack
      repeat (2) @(posedge clk_i);
      while (timer_zero_irq_o !== 1'b1 && n < lim) begin
         @(posedge clk_i);
         n++;
      end
      if (timer_zero_irq_o !== 1'b1) give_up();
   endtask
   task automatic wait_ticks(input int n);
      repeat (n) @(posedge lsclk_i);
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      // reset values, unmapped and read-only places
      foreach (rows[i]) begin
         bus(rows[i].we, rows[i].adr, rows[i].d, rd_val);
         if (!rows[i].we) check(rd_val, rows[i].d);
      end
      $display("register table done");
      // periodic, pattern 0 then 1, masked at first
      wr(`OFS_TIMER_CONTROL, 32'h00000021);
      wait_ticks(9);
      check({31'h0, timer_zero_irq_o}, 32'h0);
      rdchk(`OFS_RAW_STATUS, 32'h2);
      rdchk(`OFS_MASKED_STATUS, 32'h0);
      wr(`OFS_FIRST_RELOAD, 32'h7);
      rdchk(`OFS_FIRST_RELOAD, 32'h3);
      wr(`OFS_IRQ_MASK, 32'h2);
      wait_irq(20);
      rdchk(`OFS_MASKED_STATUS, 32'h2);
      wr(`OFS_IRQ_CLEAR, 32'h2);
      rdchk(`OFS_RAW_STATUS, 32'h0);
      wait_irq(7000);
      t1 = tick_cnt;
      wr(`OFS_IRQ_CLEAR, 32'h2);
      wait_irq(7000);
      t2 = tick_cnt;
      wr(`OFS_IRQ_CLEAR, 32'h2);
      wait_irq(7000);
      t3 = tick_cnt;
      check(32'(t2 - t1), 32'h4);
      check(32'(t3 - t2), 32'h6);
      $display("periodic done");
      // one-shot: halt at zero, restart by reload write
      wr(`OFS_TIMER_CONTROL, 32'h0);
      wait_ticks(5);
      wr(`OFS_IRQ_CLEAR, 32'h2);
      wr(`OFS_PATTERN_BASE, 32'h0);
      wr(`OFS_TIMER_CONTROL, 32'h3);
      wait_irq(7500);
      wr(`OFS_IRQ_CLEAR, 32'h2);
      wait_ticks(10);
      check({31'h0, timer_zero_irq_o}, 32'h0);
      rdchk(`OFS_DOWN_COUNT, 32'h0);
      rdchk(`OFS_TIMER_CONTROL, 32'h2);
      wr(`OFS_FIRST_RELOAD, 32'h2);
      rdchk(`OFS_FIRST_RELOAD, 32'h2);
      wait_irq(5000);
      check({31'h0, timer_zero_irq_o}, 32'h1);
      $display("one-shot done");
      // self-start after a second reload write
      wr(`OFS_IRQ_CLEAR, 32'h2);
      wr(`OFS_TIMER_CONTROL, 32'h6);
      wait_ticks(2);
      rdchk(`OFS_TIMER_CONTROL, 32'h6);
      wr(`OFS_SECOND_RELOAD, 32'h4);
      wait_irq(6250);
      check({31'h0, timer_zero_irq_o}, 32'h1);
      $display("self-start done");
      // reset after the one-shot halt, interrupt line still high
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check({31'h0, timer_zero_irq_o}, 32'h0);
      rdchk(`OFS_TIMER_CONTROL, 32'h0);
      rdchk(`OFS_DOWN_COUNT, 32'h0FFFFFFF);
      $display("reset done");
      tally_and_finish();
   end
endmodule // testbench
